//--- pkg/ifsb_pkg.sv
// Constants for the interrupt flag status bank
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package ifsb_pkg;

    localparam int          FLAG_W     = 16;
    localparam int          NUM_GROUPS = 3;
    localparam int          ADDR_W     = 8;

    // Register byte offsets
    localparam logic [7:0]  OFS_FLAGS0 = 8'h00;
    localparam logic [7:0]  OFS_FLAGS1 = 8'h04;
    localparam logic [7:0]  OFS_FLAGS2 = 8'h08;
    localparam logic [7:0]  OFS_ENA0   = 8'h0c;
    localparam logic [7:0]  OFS_ENA1   = 8'h10;
    localparam logic [7:0]  OFS_ENA2   = 8'h14;
    localparam logic [7:0]  OFS_EVSTAT = 8'h18;
    localparam logic [7:0]  OFS_EVCLR  = 8'h1c;
    localparam logic [7:0]  OFS_EVEN   = 8'h20;

    // Implemented bit masks per group and reset values
    localparam logic [15:0] IMPL0      = 16'h3fef;
    localparam logic [15:0] IMPL1      = 16'hfedf;
    localparam logic [15:0] IMPL2      = 16'h3fe3;
    localparam logic [15:0] FLAG_RST   = 16'h0000;
    localparam logic [2:0]  EV_RST     = 3'h0;

    // Group0 bit positions
    localparam int B_ADC_DONE   = 13;
    localparam int B_SER1_TX    = 12;
    localparam int B_SER1_RX    = 11;
    localparam int B_SP1_EVT    = 10;
    localparam int B_SP1_FLT    = 9;
    localparam int B_TMR3       = 8;
    localparam int B_TMR2       = 7;
    localparam int B_CMP2       = 6;
    localparam int B_CAP2       = 5;
    localparam int B_TMR1       = 3;
    localparam int B_CMP1       = 2;
    localparam int B_CAP1       = 1;
    localparam int B_EXT0       = 0;
    // Group1 bit positions
    localparam int B_SER2_TX    = 15;
    localparam int B_SER2_RX    = 14;
    localparam int B_EXT2       = 13;
    localparam int B_TMR5       = 12;
    localparam int B_TMR4       = 11;
    localparam int B_CMP4       = 10;
    localparam int B_CMP3       = 9;
    localparam int B_CAP8       = 7;
    localparam int B_CAP7       = 6;
    localparam int B_EXT1       = 4;
    localparam int B_PIN_CHG    = 3;
    localparam int B_COMPARATOR = 2;
    localparam int B_TW1_MST    = 1;
    localparam int B_TW1_SLV    = 0;
    // Group2 bit positions
    localparam int B_PAR_PORT   = 13;
    localparam int B_CMP8       = 12;
    localparam int B_CMP7       = 11;
    localparam int B_CMP6       = 10;
    localparam int B_CMP5       = 9;
    localparam int B_CAP6       = 8;
    localparam int B_CAP5       = 7;
    localparam int B_CAP4       = 6;
    localparam int B_CAP3       = 5;
    localparam int B_SP2_EVT    = 1;
    localparam int B_SP2_FLT    = 0;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE    = 2'b00,
        BUS_RD_WAIT = 2'b01,
        BUS_RD_DONE = 2'b10
    } ifsb_bus_type;

endpackage

//--- hdl/ifsb_flag_word.sv
// One group of sticky request flags with software read/write access
`timescale 1ns/100ps
module ifsb_flag_word #(
    parameter int              W    = 16,
    parameter logic [W-1:0]    IMPL = '1
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Source requests
    input  wire logic [W-1:0]  set_req,
    // Software write
    input  wire logic          wr_en,
    input  wire logic [W-1:0]  wr_data,
    // Flag state
    output logic      [W-1:0]  flags
);

    logic [W-1:0] flags_ff;
    logic [W-1:0] nxt_flags;

    always_comb begin
        nxt_flags = wr_en ? wr_data : flags_ff;
        nxt_flags = (nxt_flags | set_req) & IMPL;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;

endmodule

//--- hdl/ifsb_top.sv
// Interrupt flag status bank with AHB-Lite register access
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module ifsb_top (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        ARST_N,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Group0 source requests
    input  wire logic        ADC_DONE_REQ,
    input  wire logic        SERIAL1_TX_REQ,
    input  wire logic        SERIAL1_RX_REQ,
    input  wire logic        SPORT1_EVENT_REQ,
    input  wire logic        SPORT1_FAULT_REQ,
    input  wire logic        TIMER3_REQ,
    input  wire logic        TIMER2_REQ,
    input  wire logic        COMPARE2_REQ,
    input  wire logic        CAPTURE2_REQ,
    input  wire logic        TIMER1_REQ,
    input  wire logic        COMPARE1_REQ,
    input  wire logic        CAPTURE1_REQ,
    input  wire logic        EXT_IRQ0_REQ,
    // Group1 source requests
    input  wire logic        SERIAL2_TX_REQ,
    input  wire logic        SERIAL2_RX_REQ,
    input  wire logic        EXT_IRQ2_REQ,
    input  wire logic        TIMER5_REQ,
    input  wire logic        TIMER4_REQ,
    input  wire logic        COMPARE4_REQ,
    input  wire logic        COMPARE3_REQ,
    input  wire logic        CAPTURE8_REQ,
    input  wire logic        CAPTURE7_REQ,
    input  wire logic        EXT_IRQ1_REQ,
    input  wire logic        PIN_CHANGE_REQ,
    input  wire logic        COMPARATOR_REQ,
    input  wire logic        TWOWIRE1_MASTER_REQ,
    input  wire logic        TWOWIRE1_SLAVE_REQ,
    // Group2 source requests
    input  wire logic        PARALLEL_PORT_REQ,
    input  wire logic        COMPARE8_REQ,
    input  wire logic        COMPARE7_REQ,
    input  wire logic        COMPARE6_REQ,
    input  wire logic        COMPARE5_REQ,
    input  wire logic        CAPTURE6_REQ,
    input  wire logic        CAPTURE5_REQ,
    input  wire logic        CAPTURE4_REQ,
    input  wire logic        CAPTURE3_REQ,
    input  wire logic        SPORT2_EVENT_REQ,
    input  wire logic        SPORT2_FAULT_REQ,
    // Flag and pending outputs
    output logic      [15:0] FLAGS0,
    output logic      [15:0] FLAGS1,
    output logic      [15:0] FLAGS2,
    output logic      [15:0] PEND0,
    output logic      [15:0] PEND1,
    output logic      [15:0] PEND2,
    output logic             CPU_IRQ,
    // Event interrupt
    output logic             EVT_IRQ
);

    localparam int GW = ifsb_pkg::FLAG_W;
    localparam int NG = ifsb_pkg::NUM_GROUPS;

    //--------------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------------
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    function automatic logic [15:0] impl_mask(input int g);
        case (g)
            0:       impl_mask = ifsb_pkg::IMPL0;
            1:       impl_mask = ifsb_pkg::IMPL1;
            default: impl_mask = ifsb_pkg::IMPL2;
        endcase
    endfunction

    //--------------------------------------------------------------------------
    // Request mapping
    //--------------------------------------------------------------------------
    logic [GW-1:0] req [NG];

    always_comb begin
        req[0] = '0;
        req[0][ifsb_pkg::B_ADC_DONE] = ADC_DONE_REQ;
        req[0][ifsb_pkg::B_SER1_TX]  = SERIAL1_TX_REQ;
        req[0][ifsb_pkg::B_SER1_RX]  = SERIAL1_RX_REQ;
        req[0][ifsb_pkg::B_SP1_EVT]  = SPORT1_EVENT_REQ;
        req[0][ifsb_pkg::B_SP1_FLT]  = SPORT1_FAULT_REQ;
        req[0][ifsb_pkg::B_TMR3]     = TIMER3_REQ;
        req[0][ifsb_pkg::B_TMR2]     = TIMER2_REQ;
        req[0][ifsb_pkg::B_CMP2]     = COMPARE2_REQ;
        req[0][ifsb_pkg::B_CAP2]     = CAPTURE2_REQ;
        req[0][ifsb_pkg::B_TMR1]     = TIMER1_REQ;
        req[0][ifsb_pkg::B_CMP1]     = COMPARE1_REQ;
        req[0][ifsb_pkg::B_CAP1]     = CAPTURE1_REQ;
        req[0][ifsb_pkg::B_EXT0]     = EXT_IRQ0_REQ;
        req[1] = '0;
        req[1][ifsb_pkg::B_SER2_TX]    = SERIAL2_TX_REQ;
        req[1][ifsb_pkg::B_SER2_RX]    = SERIAL2_RX_REQ;
        req[1][ifsb_pkg::B_EXT2]       = EXT_IRQ2_REQ;
        req[1][ifsb_pkg::B_TMR5]       = TIMER5_REQ;
        req[1][ifsb_pkg::B_TMR4]       = TIMER4_REQ;
        req[1][ifsb_pkg::B_CMP4]       = COMPARE4_REQ;
        req[1][ifsb_pkg::B_CMP3]       = COMPARE3_REQ;
        req[1][ifsb_pkg::B_CAP8]       = CAPTURE8_REQ;
        req[1][ifsb_pkg::B_CAP7]       = CAPTURE7_REQ;
        req[1][ifsb_pkg::B_EXT1]       = EXT_IRQ1_REQ;
        req[1][ifsb_pkg::B_PIN_CHG]    = PIN_CHANGE_REQ;
        req[1][ifsb_pkg::B_COMPARATOR] = COMPARATOR_REQ;
        req[1][ifsb_pkg::B_TW1_MST]    = TWOWIRE1_MASTER_REQ;
        req[1][ifsb_pkg::B_TW1_SLV]    = TWOWIRE1_SLAVE_REQ;
        req[2] = '0;
        req[2][ifsb_pkg::B_PAR_PORT] = PARALLEL_PORT_REQ;
        req[2][ifsb_pkg::B_CMP8]     = COMPARE8_REQ;
        req[2][ifsb_pkg::B_CMP7]     = COMPARE7_REQ;
        req[2][ifsb_pkg::B_CMP6]     = COMPARE6_REQ;
        req[2][ifsb_pkg::B_CMP5]     = COMPARE5_REQ;
        req[2][ifsb_pkg::B_CAP6]     = CAPTURE6_REQ;
        req[2][ifsb_pkg::B_CAP5]     = CAPTURE5_REQ;
        req[2][ifsb_pkg::B_CAP4]     = CAPTURE4_REQ;
        req[2][ifsb_pkg::B_CAP3]     = CAPTURE3_REQ;
        req[2][ifsb_pkg::B_SP2_EVT]  = SPORT2_EVENT_REQ;
        req[2][ifsb_pkg::B_SP2_FLT]  = SPORT2_FAULT_REQ;
    end

    //--------------------------------------------------------------------------
    // AHB-Lite slave
    //--------------------------------------------------------------------------
    ifsb_pkg::ifsb_bus_type bus_state_ff;
    ifsb_pkg::ifsb_bus_type nxt_bus_state;
    logic        wr_ff;
    logic [7:0]  addr_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rd_mux;
    logic        take;
    logic        wr_go;

    assign take  = HSEL && HTRANS[1] && HREADY;
    assign wr_go = wr_ff && HREADY;

    always_comb begin
        nxt_bus_state = bus_state_ff;
        case (bus_state_ff)
            ifsb_pkg::BUS_IDLE: begin
                if (take && !HWRITE) begin
                    nxt_bus_state = ifsb_pkg::BUS_RD_WAIT;
                end
            end
            ifsb_pkg::BUS_RD_WAIT: begin
                nxt_bus_state = ifsb_pkg::BUS_RD_DONE;
            end
            ifsb_pkg::BUS_RD_DONE: begin
                if (take && !HWRITE) begin
                    nxt_bus_state = ifsb_pkg::BUS_RD_WAIT;
                end else begin
                    nxt_bus_state = ifsb_pkg::BUS_IDLE;
                end
            end
            default: begin
                nxt_bus_state = ifsb_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bus_state_ff <= ifsb_pkg::BUS_IDLE;
        end else begin
            bus_state_ff <= nxt_bus_state;
        end
    end

    // Address phase capture
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_ff   <= 1'b0;
            addr_ff <= 8'h00;
        end else if (HREADY) begin
            wr_ff <= take && HWRITE;
            if (take) begin
                addr_ff <= HADDR[ifsb_pkg::ADDR_W-1:0];
            end
        end
    end

    // Read data loaded during the wait cycle so earlier writes are visible
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus_state_ff == ifsb_pkg::BUS_RD_WAIT) begin
            rdata_ff <= rd_mux;
        end
    end

    assign HRDATA    = rdata_ff;
    assign HREADYOUT = (bus_state_ff != ifsb_pkg::BUS_RD_WAIT);
    assign HRESP     = 1'b0;

    //--------------------------------------------------------------------------
    // Flag groups and enables
    //--------------------------------------------------------------------------
    logic [GW-1:0] flags [NG];
    logic [GW-1:0] ena_ff [NG];
    logic [GW-1:0] pend [NG];
    logic [NG-1:0] grp_pend;
    logic [NG-1:0] grp_evt;
    logic [7:0]    flag_ofs [NG];
    logic [7:0]    ena_ofs [NG];

    assign flag_ofs[0] = ifsb_pkg::OFS_FLAGS0;
    assign flag_ofs[1] = ifsb_pkg::OFS_FLAGS1;
    assign flag_ofs[2] = ifsb_pkg::OFS_FLAGS2;
    assign ena_ofs[0]  = ifsb_pkg::OFS_ENA0;
    assign ena_ofs[1]  = ifsb_pkg::OFS_ENA1;
    assign ena_ofs[2]  = ifsb_pkg::OFS_ENA2;

    generate
        for (genvar g = 0; g < NG; g++) begin : g_grp
            ifsb_flag_word #(
                .W    (GW),
                .IMPL (impl_mask(g))
            ) u_flags (
                .clk     (MCLK),
                .rst_n   (ARST_N),
                .set_req (req[g]),
                .wr_en   (wr_go && addr_hit(addr_ff, flag_ofs[g])),
                .wr_data (HWDATA[GW-1:0]),
                .flags   (flags[g])
            );

            always_ff @(posedge MCLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    ena_ff[g] <= ifsb_pkg::FLAG_RST;
                end else if (wr_go && addr_hit(addr_ff, ena_ofs[g])) begin
                    ena_ff[g] <= HWDATA[GW-1:0] & impl_mask(g);
                end
            end

            assign pend[g]     = flags[g] & ena_ff[g];
            assign grp_pend[g] = |pend[g];
            assign grp_evt[g]  = |(req[g] & impl_mask(g));
        end
    endgenerate

    assign FLAGS0  = flags[0];
    assign FLAGS1  = flags[1];
    assign FLAGS2  = flags[2];
    assign PEND0   = pend[0];
    assign PEND1   = pend[1];
    assign PEND2   = pend[2];
    assign CPU_IRQ = |grp_pend;

    //--------------------------------------------------------------------------
    // Event status, clear and enable
    //--------------------------------------------------------------------------
    logic [NG-1:0] ev_stat_ff;
    logic [NG-1:0] ev_en_ff;
    logic [NG-1:0] ev_clr;

    assign ev_clr = (wr_go && addr_hit(addr_ff, ifsb_pkg::OFS_EVCLR)) ? HWDATA[NG-1:0] : '0;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ev_stat_ff <= ifsb_pkg::EV_RST;
        end else begin
            ev_stat_ff <= (ev_stat_ff & ~ev_clr) | grp_evt;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ev_en_ff <= ifsb_pkg::EV_RST;
        end else if (wr_go && addr_hit(addr_ff, ifsb_pkg::OFS_EVEN)) begin
            ev_en_ff <= HWDATA[NG-1:0];
        end
    end

    assign EVT_IRQ = |(ev_stat_ff & ev_en_ff);

    //--------------------------------------------------------------------------
    // Read multiplexer
    //--------------------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr_ff)
            ifsb_pkg::OFS_FLAGS0: rd_mux[GW-1:0] = flags[0];
            ifsb_pkg::OFS_FLAGS1: rd_mux[GW-1:0] = flags[1];
            ifsb_pkg::OFS_FLAGS2: rd_mux[GW-1:0] = flags[2];
            ifsb_pkg::OFS_ENA0:   rd_mux[GW-1:0] = ena_ff[0];
            ifsb_pkg::OFS_ENA1:   rd_mux[GW-1:0] = ena_ff[1];
            ifsb_pkg::OFS_ENA2:   rd_mux[GW-1:0] = ena_ff[2];
            ifsb_pkg::OFS_EVSTAT: rd_mux[NG-1:0] = ev_stat_ff;
            ifsb_pkg::OFS_EVEN:   rd_mux[NG-1:0] = ev_en_ff;
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

endmodule

//--- verif/ifsb_checker.sv
// Assertion checker for the interrupt flag status bank
`timescale 1ns/100ps
module ifsb_checker (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        ARST_N,
    // Register bus
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    // Sampled sources
    input wire logic        ADC_DONE_REQ,
    input wire logic        EXT_IRQ0_REQ,
    input wire logic        SERIAL2_TX_REQ,
    input wire logic        PARALLEL_PORT_REQ,
    // Flags and pending
    input wire logic [15:0] FLAGS0,
    input wire logic [15:0] FLAGS1,
    input wire logic [15:0] FLAGS2,
    input wire logic [15:0] PEND0,
    input wire logic [15:0] PEND1,
    input wire logic [15:0] PEND2,
    input wire logic        CPU_IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    //--------------------------------------------------------------------------
    // Helper logic
    //--------------------------------------------------------------------------
    logic wr_dp_ff;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N)
            wr_dp_ff <= 1'b0;
        else
            wr_dp_ff <= HSEL & HTRANS[1] & HWRITE & HREADY;
    end

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    a_adc_sets_flag: assert property (ADC_DONE_REQ |=> FLAGS0[13])
        else $error("adc done request did not set its flag");
    a_ext0_sets_flag: assert property (EXT_IRQ0_REQ |=> FLAGS0[0])
        else $error("ext irq0 request did not set bit 0");
    a_ser2_sets_flag: assert property (SERIAL2_TX_REQ |=> FLAGS1[15])
        else $error("serial2 tx request did not set bit 15");
    a_pport_sets_flag: assert property (PARALLEL_PORT_REQ |=> FLAGS2[13])
        else $error("parallel port request did not set bit 13");
    a_unimpl_zero: assert property ((FLAGS0 & ~ifsb_pkg::IMPL0) == 16'h0 &&
        (FLAGS1 & ~ifsb_pkg::IMPL1) == 16'h0 && (FLAGS2 & ~ifsb_pkg::IMPL2) == 16'h0)
        else $error("unimplemented flag bit set");
    a_pend_in_flags: assert property ((PEND0 & ~FLAGS0) == 16'h0 &&
        (PEND1 & ~FLAGS1) == 16'h0 && (PEND2 & ~FLAGS2) == 16'h0)
        else $error("pending bit without its flag");
    a_irq_level: assert property (CPU_IRQ == (|{PEND0, PEND1, PEND2}))
        else $error("cpu interrupt does not follow pending bits");
    a_flag_sticky: assert property (|(($past(FLAGS0) & ~FLAGS0) |
        ($past(FLAGS1) & ~FLAGS1) | ($past(FLAGS2) & ~FLAGS2)) |-> $past(wr_dp_ff))
        else $error("flag cleared without a software write");
    a_read_wait: assert property (HSEL && HTRANS[1] && !HWRITE && HREADY
        |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state not exactly one cycle");
    a_resp_okay: assert property (HRESP == 1'b0)
        else $error("error response seen");
    a_reset_clear: assert property ($rose(ARST_N) |->
        {FLAGS0, FLAGS1, FLAGS2} == 48'h0 && !CPU_IRQ)
        else $error("flags not clear after reset");

    c_adc_flag: cover property (ADC_DONE_REQ ##1 FLAGS0[13]);
    c_cpu_irq: cover property ($rose(CPU_IRQ));
    c_read: cover property (HSEL && HTRANS[1] && !HWRITE ##1 !HREADYOUT);
endmodule

bind ifsb_top ifsb_checker u_chk (
    .MCLK, .ARST_N, .HSEL, .HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRESP,
    .ADC_DONE_REQ, .EXT_IRQ0_REQ, .SERIAL2_TX_REQ, .PARALLEL_PORT_REQ,
    .FLAGS0, .FLAGS1, .FLAGS2, .PEND0, .PEND1, .PEND2, .CPU_IRQ
);

//--- verif/test_irq_flag_status_bank.sv
// Self-checking testbench for the interrupt flag status bank
`timescale 1ns/100ps
module test_irq_flag_status_bank;
    localparam logic [2:0][15:0] impl_mask = {ifsb_pkg::IMPL2, ifsb_pkg::IMPL1, ifsb_pkg::IMPL0};

    logic              mclk;
    logic              arst_n;
    logic              hsel;
    logic       [31:0] haddr;
    logic       [1:0]  htrans;
    logic              hwrite;
    logic       [31:0] hwdata;
    wire logic  [31:0] hrdata;
    wire logic         hreadyout;
    wire logic         hresp;
    logic [2:0][15:0]  rq;
    wire [2:0][15:0]   fl;
    wire [2:0][15:0]   pd;
    wire logic         cpu_irq;
    wire logic         evt_irq;
    logic       [31:0] rd;
    int                bad_count;
    int                checks_done;
    int                cyc = 0;

    ifsb_top dut (
        .MCLK(mclk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .ADC_DONE_REQ(rq[0][13]), .SERIAL1_TX_REQ(rq[0][12]),
        .SERIAL1_RX_REQ(rq[0][11]), .SPORT1_EVENT_REQ(rq[0][10]),
        .SPORT1_FAULT_REQ(rq[0][9]), .TIMER3_REQ(rq[0][8]), .TIMER2_REQ(rq[0][7]),
        .COMPARE2_REQ(rq[0][6]), .CAPTURE2_REQ(rq[0][5]), .TIMER1_REQ(rq[0][3]),
        .COMPARE1_REQ(rq[0][2]), .CAPTURE1_REQ(rq[0][1]), .EXT_IRQ0_REQ(rq[0][0]),
        .SERIAL2_TX_REQ(rq[1][15]), .SERIAL2_RX_REQ(rq[1][14]),
        .EXT_IRQ2_REQ(rq[1][13]), .TIMER5_REQ(rq[1][12]), .TIMER4_REQ(rq[1][11]),
        .COMPARE4_REQ(rq[1][10]), .COMPARE3_REQ(rq[1][9]), .CAPTURE8_REQ(rq[1][7]),
        .CAPTURE7_REQ(rq[1][6]), .EXT_IRQ1_REQ(rq[1][4]), .PIN_CHANGE_REQ(rq[1][3]),
        .COMPARATOR_REQ(rq[1][2]), .TWOWIRE1_MASTER_REQ(rq[1][1]),
        .TWOWIRE1_SLAVE_REQ(rq[1][0]), .PARALLEL_PORT_REQ(rq[2][13]),
        .COMPARE8_REQ(rq[2][12]), .COMPARE7_REQ(rq[2][11]), .COMPARE6_REQ(rq[2][10]),
        .COMPARE5_REQ(rq[2][9]), .CAPTURE6_REQ(rq[2][8]), .CAPTURE5_REQ(rq[2][7]),
        .CAPTURE4_REQ(rq[2][6]), .CAPTURE3_REQ(rq[2][5]), .SPORT2_EVENT_REQ(rq[2][1]),
        .SPORT2_FAULT_REQ(rq[2][0]),
        .FLAGS0(fl[0]), .FLAGS1(fl[1]), .FLAGS2(fl[2]),
        .PEND0(pd[0]), .PEND1(pd[1]), .PEND2(pd[2]), .CPU_IRQ(cpu_irq), .EVT_IRQ(evt_irq)
    );

    //--------------------------------------------------------------------------
    // Tasks
    //--------------------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= 1'b1;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= 1'b0;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        chk(hrdata, exp);
    endtask

    task pulse(input int g, input int b);
        rq[g][b] <= 1'b1;
        @(posedge mclk);
        rq[g][b] <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task results;
        $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    //--------------------------------------------------------------------------
    // Clock and timeout
    //--------------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end

    //--------------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rq = '0;
        bad_count = 0;
        checks_done = 0;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        for (int a = 0; a < 9; a++)
            rd_chk(8'(4 * a), 32'h0);
        for (int g = 0; g < 3; g++) begin
            bus_wr(8'(4 * g), 32'hffff_ffff);
            rd_chk(8'(4 * g), {16'h0, impl_mask[g]});
            bus_wr(8'(4 * g), 32'h0);
            rd_chk(8'(4 * g), 32'h0);
        end
        // Each source lands on its own bit only, and holds after the request drops
        for (int g = 0; g < 3; g++) begin
            for (int b = 0; b < 16; b++) begin
                if (impl_mask[g][b]) begin
                    pulse(g, b);
                    chk({16'h0, fl[g]}, 32'h1 << b);
                    bus_wr(8'(4 * g), 32'h0);
                end
            end
        end
        // Event status, its interrupt, mask and clear
        rd_chk(8'h18, 32'h7);
        bus_wr(8'h20, 32'h2);
        @(posedge mclk);
        chk({31'h0, evt_irq}, 32'h1);
        bus_wr(8'h20, 32'h0);
        @(posedge mclk);
        chk({31'h0, evt_irq}, 32'h0);
        bus_wr(8'h20, 32'h2);
        bus_wr(8'h1c, 32'h2);
        @(posedge mclk);
        chk({31'h0, evt_irq}, 32'h0);
        bus_wr(8'h18, 32'h0);
        rd_chk(8'h18, 32'h5);
        bus_wr(8'h1c, 32'h7);
        rd_chk(8'h18, 32'h0);
        bus_wr(8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0);
        rd_chk(8'h00, 32'h0);
        // Request coinciding with a software clear
        rq[0][0] <= 1'b1;
        bus_wr(8'h00, 32'h0);
        rq[0][0] <= 1'b0;
        rd_chk(8'h00, 32'h1);
        bus_wr(8'h00, 32'h0);
        rd_chk(8'h00, 32'h0);
        // Enable gating of pending bits
        bus_wr(8'h0c, 32'h2000);
        bus_wr(8'h00, 32'hffff);
        @(posedge mclk);
        chk({16'h0, pd[0]}, 32'h2000);
        chk({31'h0, cpu_irq}, 32'h1);
        bus_wr(8'h0c, 32'h0);
        @(posedge mclk);
        chk({31'h0, cpu_irq}, 32'h0);
        rd_chk(8'h00, {16'h0, ifsb_pkg::IMPL0});
        bus_wr(8'h10, 32'hffff_ffff);
        rd_chk(8'h10, {16'h0, ifsb_pkg::IMPL1});
        bus_wr(8'h04, 32'h8000);
        @(posedge mclk);
        chk({16'h0, pd[1]}, 32'h8000);
        // Reset in mid-run
        bus_wr(8'h14, 32'h0001);
        bus_wr(8'h08, 32'hffff);
        @(posedge mclk);
        chk({16'h0, pd[2]}, 32'h0001);
        arst_n <= 1'b0;
        @(posedge mclk);
        chk({16'h0, fl[2]}, 32'h0);
        chk({31'h0, cpu_irq}, 32'h0);
        arst_n <= 1'b1;
        @(posedge mclk);
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h10, 32'h0);
        results();
    end
endmodule
